// file: inc/lad_pkg.sv
// Purpose: Shared constants and types of the line alarm detector
// Assumes: 32-bit APB, byte address is four times the register index
// Notes: Window and threshold figures are named here once
`default_nettype none
package lad_pkg;
  // Register indices; byte address is index * 4
  localparam logic [7:0] IDX_STATE = 8'h00_B9;
  localparam logic [7:0] IDX_IRQ_EN = 8'h00_BA;
  localparam logic [7:0] IDX_FLAGS = 8'h00_BB;
  localparam logic [7:0] IDX_RED_DECL = 8'h00_BC;
  localparam logic [7:0] IDX_RED_CLR = 8'h00_BD;
  localparam logic [7:0] IDX_YEL_DECL = 8'h00_BE;
  localparam logic [7:0] IDX_YEL_CLR = 8'h00_BF;
  localparam logic [7:0] IDX_AIS_DECL = 8'h00_C0;
  localparam logic [7:0] IDX_AIS_CLR = 8'h00_C1;
  localparam logic [7:0] IDX_FORMAT = 8'h00_C8;
  // Bit positions shared by state, enable and flag registers
  localparam int BIT_RED = 0;
  localparam int BIT_YEL = 1;
  localparam int BIT_AIS = 2;
  // Reset values
  localparam logic [7:0] RST_RED_DECL = 8'h00_3F;
  localparam logic [7:0] RST_RED_CLR = 8'h00_7F;
  localparam logic [7:0] RST_YEL_DECL = 8'h00_0A;
  localparam logic [7:0] RST_YEL_CLR = 8'h00_0A;
  localparam logic [7:0] RST_AIS_DECL = 8'h00_3F;
  localparam logic [7:0] RST_AIS_CLR = 8'h00_3F;
  // Window thresholds: alarm-like when below (or above for T1 ESF)
  localparam logic [15:0] AIS_ZERO_MIN = 16'h003D;
  localparam logic [15:0] SF_ONES_MIN = 16'h004D;
  localparam logic [15:0] ESF_PAT_MAX = 16'h0007;
  localparam logic [15:0] DM_ONES_MIN = 16'h0004;
  localparam logic [15:0] J1SF_ZERO_MIN = 16'h0004;
  localparam logic [15:0] J1ESF_ZERO_MIN = 16'h0003;
  localparam logic [15:0] ESF_PATTERN = 16'hFF00;
  // Timing
  localparam int unsigned WINDOW_MS = 40;
  localparam int unsigned RED_CLR_UNIT_MS = 120;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned WINDOW_CYCLES = WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0] RED_CLR_WINDOWS = 2'(RED_CLR_UNIT_MS / WINDOW_MS);
  typedef enum logic [2:0] {FMT_T1_SF, FMT_SLC96, FMT_T1_ESF, FMT_T1_DM, FMT_J1_SF, FMT_J1_ESF} lad_fmt_type;
  // One received bit with its position markers from the framer
  typedef struct packed {
    logic valid;
    logic value;
    logic chan_bit2;
    logic y_bit;
    logic f12_bit;
    logic dl_bit;
  } lad_line_type;
endpackage
`default_nettype wire

// file: core/lad_top.sv
// Purpose: Blue, remote (yellow) and sync-loss alarm detector with APB registers
// Assumes: Framer marks each received bit and reports frame sync, all on pclk
// Notes: Windows are fixed and non-overlapping, counted on pclk
//
// The APB register port was chosen for this implementation.
`default_nettype none
module lad_top #(
  parameter int unsigned WINDOW_CYCLES = lad_pkg::WINDOW_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lad_pkg::lad_line_type line_in,
  input wire logic frame_sync,
  output logic irq
);
  logic [2:0] state_r;
  logic [2:0] irq_en_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic [7:0] red_decl_r;
  logic [7:0] red_clr_r;
  logic [7:0] yel_decl_r;
  logic [7:0] yel_clr_r;
  logic [7:0] ais_decl_r;
  logic [7:0] ais_clr_r;
  lad_pkg::lad_fmt_type fmt_r;
  logic [31:0] win_cnt_r;
  logic win_end;
  logic [15:0] zero_cnt_r;
  logic [15:0] yev_cnt_r;
  logic [15:0] dl_sh_r;
  logic [15:0] dl_sh_nxt;
  logic yel_sync_ok_r;
  logic red_out_all_r;
  logic red_in_all_r;
  logic [9:0] ais_pcnt_r;
  logic [9:0] yel_pcnt_r;
  logic [9:0] red_pcnt_r;
  logic [9:0] red_clr_lim;
  logic yev;
  logic ais_like;
  logic yel_like;
  logic [10:0] ais_step;
  logic [10:0] yel_step;
  logic [10:0] red_step;
  logic [2:0] state_nxt;
  logic [7:0] idx;
  logic mapped;
  logic wr_acc;

  // Persistence step: returns {state, counter}
  function automatic logic [10:0] lad_persist(input logic st, input logic [9:0] cnt,
                                              input logic hit, input logic [9:0] lim);
    logic [9:0] c;
    c = cnt + 10'h001;
    if (!hit) begin
      return {st, 10'h000};
    end
    if (c >= lim) begin
      return {~st, 10'h000};
    end
    return {st, c};
  endfunction

  function automatic logic lad_idx_ok(input logic [7:0] i);
    return (i >= lad_pkg::IDX_STATE && i <= lad_pkg::IDX_AIS_CLR) || i == lad_pkg::IDX_FORMAT;
  endfunction

  // Alarm-like window per framing format
  function automatic logic lad_yel_alarm(input lad_pkg::lad_fmt_type f, input logic [15:0] n);
    case (f)
      lad_pkg::FMT_T1_SF, lad_pkg::FMT_SLC96: return n < lad_pkg::SF_ONES_MIN;
      lad_pkg::FMT_T1_ESF: return n > lad_pkg::ESF_PAT_MAX;
      lad_pkg::FMT_T1_DM: return n < lad_pkg::DM_ONES_MIN;
      lad_pkg::FMT_J1_SF: return n < lad_pkg::J1SF_ZERO_MIN;
      lad_pkg::FMT_J1_ESF: return n < lad_pkg::J1ESF_ZERO_MIN;
      default: return 1'b0;
    endcase
  endfunction

  assign idx = paddr[9:2];
  assign mapped = lad_idx_ok(idx) && paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Window timer
  assign win_end = win_cnt_r == WINDOW_CYCLES - 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= 32'h0000_0000;
    end else if (win_end) begin
      win_cnt_r <= 32'h0000_0000;
    end else begin
      win_cnt_r <= win_cnt_r + 32'h0000_0001;
    end
  end

  // Yellow event for the selected format
  assign dl_sh_nxt = {dl_sh_r[14:0], line_in.value};
  always_comb begin
    yev = 1'b0;
    if (line_in.valid) begin
      case (fmt_r)
        lad_pkg::FMT_T1_SF, lad_pkg::FMT_SLC96: yev = line_in.chan_bit2 && line_in.value;
        lad_pkg::FMT_T1_ESF: yev = line_in.dl_bit && dl_sh_nxt == lad_pkg::ESF_PATTERN;
        lad_pkg::FMT_T1_DM: yev = line_in.y_bit && line_in.value;
        lad_pkg::FMT_J1_SF: yev = line_in.f12_bit && !line_in.value;
        lad_pkg::FMT_J1_ESF: yev = line_in.dl_bit && !line_in.value;
        default: yev = 1'b0;
      endcase
    end
  end

  // DL bits slide through a 16-bit pattern register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_sh_r <= 16'h0000;
    end else if (line_in.valid && line_in.dl_bit) begin
      dl_sh_r <= dl_sh_nxt;
    end
  end

  // Per-window event counters, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt_r <= 16'h0000;
      yev_cnt_r <= 16'h0000;
    end else if (win_end) begin
      zero_cnt_r <= 16'h0000;
      yev_cnt_r <= 16'h0000;
    end else begin
      if (line_in.valid && !line_in.value && zero_cnt_r != 16'hFFFF) begin
        zero_cnt_r <= zero_cnt_r + 16'h0001;
      end
      if (yev && frame_sync && yev_cnt_r != 16'hFFFF) begin
        yev_cnt_r <= yev_cnt_r + 16'h0001;
      end
    end
  end

  // Sync history within the current window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      yel_sync_ok_r <= 1'b1;
      red_out_all_r <= 1'b1;
      red_in_all_r <= 1'b1;
    end else if (win_end) begin
      yel_sync_ok_r <= 1'b1;
      red_out_all_r <= 1'b1;
      red_in_all_r <= 1'b1;
    end else begin
      yel_sync_ok_r <= yel_sync_ok_r && frame_sync;
      red_out_all_r <= red_out_all_r && !frame_sync;
      red_in_all_r <= red_in_all_r && frame_sync;
    end
  end

  // Window verdicts include the window's last cycle
  assign ais_like = zero_cnt_r + {15'h0000, line_in.valid && !line_in.value} < lad_pkg::AIS_ZERO_MIN;
  assign yel_like = lad_yel_alarm(fmt_r, yev_cnt_r + {15'h0000, yev && frame_sync});
  assign red_clr_lim = 10'({2'b00, red_clr_r} * lad_pkg::RED_CLR_WINDOWS);

  always_comb begin
    ais_step = lad_persist(state_r[lad_pkg::BIT_AIS], ais_pcnt_r, ais_like ^ state_r[lad_pkg::BIT_AIS],
                           state_r[lad_pkg::BIT_AIS] ? {2'b00, ais_clr_r} : {2'b00, ais_decl_r});
    yel_step = lad_persist(state_r[lad_pkg::BIT_YEL], yel_pcnt_r, yel_like ^ state_r[lad_pkg::BIT_YEL],
                           state_r[lad_pkg::BIT_YEL] ? {2'b00, yel_clr_r} : {2'b00, yel_decl_r});
    red_step = lad_persist(state_r[lad_pkg::BIT_RED], red_pcnt_r,
                           state_r[lad_pkg::BIT_RED] ? red_in_all_r && frame_sync : red_out_all_r && !frame_sync,
                           state_r[lad_pkg::BIT_RED] ? red_clr_lim : {2'b00, red_decl_r});
    state_nxt = state_r;
    if (win_end) begin
      state_nxt[lad_pkg::BIT_AIS] = ais_step[10];
      state_nxt[lad_pkg::BIT_RED] = red_step[10];
      if (yel_sync_ok_r && frame_sync) begin
        state_nxt[lad_pkg::BIT_YEL] = yel_step[10];
      end
    end
  end

  // Alarm state and persistence counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= 3'b000;
      ais_pcnt_r <= 10'h000;
      yel_pcnt_r <= 10'h000;
      red_pcnt_r <= 10'h000;
    end else if (win_end) begin
      state_r <= state_nxt;
      ais_pcnt_r <= ais_step[9:0];
      red_pcnt_r <= red_step[9:0];
      yel_pcnt_r <= (yel_sync_ok_r && frame_sync) ? yel_step[9:0] : 10'h000;
    end
  end

  // Change flags: a toggle wins over a clear in the same cycle
  assign flags_nxt = (flags_r & ~((wr_acc && idx == lad_pkg::IDX_FLAGS) ? pwdata[2:0] : 3'b000))
                     | (state_nxt ^ state_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign irq = |(flags_r & irq_en_r);

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 3'b000;
      red_decl_r <= lad_pkg::RST_RED_DECL;
      red_clr_r <= lad_pkg::RST_RED_CLR;
      yel_decl_r <= lad_pkg::RST_YEL_DECL;
      yel_clr_r <= lad_pkg::RST_YEL_CLR;
      ais_decl_r <= lad_pkg::RST_AIS_DECL;
      ais_clr_r <= lad_pkg::RST_AIS_CLR;
      fmt_r <= lad_pkg::FMT_T1_SF;
    end else if (wr_acc) begin
      case (idx)
        lad_pkg::IDX_IRQ_EN: irq_en_r <= pwdata[2:0];
        lad_pkg::IDX_RED_DECL: red_decl_r <= pwdata[7:0];
        lad_pkg::IDX_RED_CLR: red_clr_r <= pwdata[7:0];
        lad_pkg::IDX_YEL_DECL: yel_decl_r <= pwdata[7:0];
        lad_pkg::IDX_YEL_CLR: yel_clr_r <= pwdata[7:0];
        lad_pkg::IDX_AIS_DECL: ais_decl_r <= pwdata[7:0];
        lad_pkg::IDX_AIS_CLR: ais_clr_r <= pwdata[7:0];
        lad_pkg::IDX_FORMAT: begin
          if (pwdata[2:0] <= 3'(lad_pkg::FMT_J1_ESF)) begin
            fmt_r <= lad_pkg::lad_fmt_type'(pwdata[2:0]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (idx)
        lad_pkg::IDX_STATE: prdata <= {29'h0000_0000, state_r};
        lad_pkg::IDX_IRQ_EN: prdata <= {29'h0000_0000, irq_en_r};
        lad_pkg::IDX_FLAGS: prdata <= {29'h0000_0000, flags_r};
        lad_pkg::IDX_RED_DECL: prdata <= {24'h00_0000, red_decl_r};
        lad_pkg::IDX_RED_CLR: prdata <= {24'h00_0000, red_clr_r};
        lad_pkg::IDX_YEL_DECL: prdata <= {24'h00_0000, yel_decl_r};
        lad_pkg::IDX_YEL_CLR: prdata <= {24'h00_0000, yel_clr_r};
        lad_pkg::IDX_AIS_DECL: prdata <= {24'h00_0000, ais_decl_r};
        lad_pkg::IDX_AIS_CLR: prdata <= {24'h00_0000, ais_clr_r};
        lad_pkg::IDX_FORMAT: prdata <= {29'h0000_0000, fmt_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  sequence s_flag_clear_wr(int b);
    psel && penable && pwrite && paddr == {2'b00, lad_pkg::IDX_FLAGS, 2'b00} && pwdata[b];
  endsequence

  AST_STATE_ON_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    state_r != $past(state_r) |-> $past(win_end)) else $error("alarm state moved off a window edge");
  AST_FLAG_ON_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_r[lad_pkg::BIT_AIS]) |-> flags_r[lad_pkg::BIT_AIS]) else $error("blue toggle left no flag");
  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    flags_r[lad_pkg::BIT_YEL] && !(wr_acc && idx == lad_pkg::IDX_FLAGS && pwdata[lad_pkg::BIT_YEL])
    |=> flags_r[lad_pkg::BIT_YEL]) else $error("remote flag lost without clear");
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_clear_wr(lad_pkg::BIT_RED) ##0 (state_nxt[lad_pkg::BIT_RED] == state_r[lad_pkg::BIT_RED])
    |=> !flags_r[lad_pkg::BIT_RED]) else $error("sync loss flag not cleared");
  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    irq_en_r == 3'b000 |-> !irq) else $error("interrupt with all enables off");
  AST_YEL_NOSYNC: assert property (@(posedge pclk) disable iff (!presetn)
    win_end && !frame_sync |=> yel_pcnt_r == 10'h000 && $stable(state_r[lad_pkg::BIT_YEL]))
    else $error("remote alarm counted without sync");
  AST_BLUE_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    win_end && !(ais_like ^ state_r[lad_pkg::BIT_AIS]) |=> ais_pcnt_r == 10'h000)
    else $error("blue counter kept after failed window");
  AST_RED_CLEAR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_r[lad_pkg::BIT_RED]) |-> $past(red_pcnt_r) + 10'h001 >= $past(red_clr_lim))
    else $error("sync loss cleared too early");
  AST_RED_DECL_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r[lad_pkg::BIT_RED]) |-> $past(red_pcnt_r) + 10'h001 >= {2'b00, $past(red_decl_r)})
    else $error("sync loss declared too early");

  // Window steps seen by the persistence checks
  sequence s_window_close;
    win_end;
  endsequence

  sequence s_red_out_window;
    win_end && red_out_all_r && !frame_sync;
  endsequence

  sequence s_red_in_window;
    win_end && red_in_all_r && frame_sync;
  endsequence

  AST_WINDOW_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    s_window_close |=> !win_end) else $error("window end lasted two cycles");
  AST_COUNT_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    s_window_close |=> zero_cnt_r == 16'h0000 && yev_cnt_r == 16'h0000)
    else $error("window counters kept across windows");
  AST_AIS_DECL_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r[lad_pkg::BIT_AIS]) |-> $past(ais_pcnt_r) + 10'h001 >= {2'b00, $past(ais_decl_r)})
    else $error("blue declared too early");
  AST_AIS_CLR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_r[lad_pkg::BIT_AIS]) |-> $past(ais_pcnt_r) + 10'h001 >= {2'b00, $past(ais_clr_r)})
    else $error("blue cleared too early");
  AST_YEL_DECL_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r[lad_pkg::BIT_YEL]) |-> $past(yel_pcnt_r) + 10'h001 >= {2'b00, $past(yel_decl_r)})
    else $error("remote alarm declared too early");
  AST_YEL_CLR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_r[lad_pkg::BIT_YEL]) |-> $past(yel_pcnt_r) + 10'h001 >= {2'b00, $past(yel_clr_r)})
    else $error("remote alarm cleared too early");
  AST_RED_OUT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    s_red_out_window ##0 !state_r[lad_pkg::BIT_RED] |=> state_r[lad_pkg::BIT_RED] || red_pcnt_r != 10'h000)
    else $error("out of sync window not counted");
  AST_RED_IN_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    s_red_in_window ##0 state_r[lad_pkg::BIT_RED] |=> !state_r[lad_pkg::BIT_RED] || red_pcnt_r != 10'h000)
    else $error("in sync window not counted");
  AST_RED_MIXED_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    win_end && !state_r[lad_pkg::BIT_RED] && !(red_out_all_r && !frame_sync)
    |=> red_pcnt_r == 10'h000 && !state_r[lad_pkg::BIT_RED]) else $error("sync loss counter kept after mixed window");
  AST_YEL_FLAG_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_r[lad_pkg::BIT_YEL]) |-> flags_r[lad_pkg::BIT_YEL]) else $error("remote toggle left no flag");
  AST_RED_FLAG_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_r[lad_pkg::BIT_RED]) |-> flags_r[lad_pkg::BIT_RED]) else $error("sync loss toggle left no flag");
  AST_W1C_AIS: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_clear_wr(lad_pkg::BIT_AIS) ##0 (state_nxt[lad_pkg::BIT_AIS] == state_r[lad_pkg::BIT_AIS])
    |=> !flags_r[lad_pkg::BIT_AIS]) else $error("blue flag not cleared");
  AST_W1C_YEL: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_clear_wr(lad_pkg::BIT_YEL) ##0 (state_nxt[lad_pkg::BIT_YEL] == state_r[lad_pkg::BIT_YEL])
    |=> !flags_r[lad_pkg::BIT_YEL]) else $error("remote flag not cleared");
endmodule // lad_top
`default_nettype wire

// file: dv/lad_line_model.sv
// Purpose: Received line source for the alarm detector
// Assumes: One marked bit per pclk, windows counted from reset release
// Notes: Event bits start at position 40 so knob changes land early in a window
`default_nettype none
module lad_line_model #(
  parameter int unsigned W = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] ev,
  input wire logic blue_kind,
  input wire lad_pkg::lad_fmt_type fmt,
  input wire logic sync_on,
  output var lad_pkg::lad_line_type line_out,
  output logic frame_sync,
  output logic win_start
);
  logic [15:0] pos_r;
  logic [15:0] k;
  logic hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pos_r <= '0;
    else pos_r <= (pos_r == 16'(W - 1)) ? 16'h0000 : pos_r + 16'h0001;
  end
  assign win_start = (pos_r == 16'h0000);
  assign frame_sync = sync_on;
  assign k = pos_r - 16'h0028;
  // T1 ESF events count whole patterns of 16 data link bits
  assign hit = (pos_r >= 16'h0028) && ((!blue_kind && fmt == lad_pkg::FMT_T1_ESF) ?
               (k < {4'h0, ev, 4'h0}) : (k < {8'h00, ev}));
  always_comb begin
    line_out = '0;
    line_out.valid = 1'b1;
    line_out.value = 1'b1;
    if (hit && blue_kind) line_out.value = 1'b0;
    else if (hit) begin
      case (fmt)
        lad_pkg::FMT_T1_ESF: begin
          line_out.dl_bit = 1'b1;
          line_out.value = ~k[3];
        end
        lad_pkg::FMT_T1_DM: line_out.y_bit = 1'b1;
        lad_pkg::FMT_J1_SF: begin
          line_out.f12_bit = 1'b1;
          line_out.value = 1'b0;
        end
        lad_pkg::FMT_J1_ESF: begin
          line_out.dl_bit = 1'b1;
          line_out.value = 1'b0;
        end
        default: line_out.chan_bit2 = 1'b1;
      endcase
    end
  end
endmodule // lad_line_model
`default_nettype wire

// file: dv/lad_top_tb.sv
// Purpose: Self-checking bench of the line alarm detector
// Assumes: Windows of WC cycles; the line model counts them from reset release
// Notes: Each phase sets the line pattern early in a window
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("[FAIL] %s expected %h seen %h", n, e, g); miscompares++; end end
module lad_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WC = 200;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blue_kind = 1, sync_on = 1;
  logic pready, pslverr, irq, frame_sync, win_start, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] ev = 8'h64, rv;
  lad_pkg::lad_fmt_type fmt = lad_pkg::FMT_T1_SF;
  lad_pkg::lad_line_type line_in;
  int miscompares = 0, tests_run = 0, seed = 32'h042b_d4eb;
  logic [7:0] ridx [9] = '{lad_pkg::IDX_STATE, lad_pkg::IDX_IRQ_EN, lad_pkg::IDX_FLAGS, lad_pkg::IDX_RED_DECL,
    lad_pkg::IDX_RED_CLR, lad_pkg::IDX_YEL_DECL, lad_pkg::IDX_YEL_CLR, lad_pkg::IDX_AIS_DECL, lad_pkg::IDX_AIS_CLR};
  logic [31:0] rval [9] = '{0, 0, 0, 32'h3F, 32'h7F, 32'h0A, 32'h0A, 32'h3F, 32'h3F};
  logic [31:0] cval [9] = '{0, 0, 0, 2, 1, 2, 2, 2, 2};
  always #2.5 pclk = ~pclk;
  lad_top #(.WINDOW_CYCLES(WC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .frame_sync(frame_sync), .irq(irq));
  lad_line_model #(.W(WC)) u_line (.pclk(pclk), .presetn(presetn), .ev(ev), .blue_kind(blue_kind), .fmt(fmt),
    .sync_on(sync_on), .line_out(line_in), .frame_sync(frame_sync), .win_start(win_start));
  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_win();
    int i;
    for (i = 0; i < 2 * WC; i++) begin
      @(posedge pclk);
      if (win_start === 1'b1) break;
    end
    if (i == 2 * WC) begin
      miscompares++;
      finish_test();
    end
  endtask
  // Pattern for the current window and n - 1 more, then a short settle
  task automatic phase(input logic [7:0] e, input logic s, input int n);
    ev <= e;
    sync_on <= s;
    repeat (n) wait_win();
    repeat (3) @(posedge pclk);
  endtask
  // Boundary event counts per format: declaring or clearing side
  function automatic logic [7:0] yel_ev(input lad_pkg::lad_fmt_type f, input logic decl);
    case (f)
      lad_pkg::FMT_T1_ESF: return decl ? 8'h08 : 8'h07;
      lad_pkg::FMT_T1_DM, lad_pkg::FMT_J1_SF: return decl ? 8'h03 : 8'h04;
      lad_pkg::FMT_J1_ESF: return decl ? 8'h02 : 8'h03;
      default: return decl ? 8'h4C : 8'h4D;
    endcase
  endfunction
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ridx[i]) begin
      apb(1'b0, ridx[i], 32'h0000_0000);
      `CHK("reset value", rval[i], rd)
    end
    apb(1'b0, 8'hF0, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1'b1, lad_pkg::IDX_STATE, 32'h0000_0007);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("state read only", 32'h0000_0000, rd)
    for (int i = 3; i < 9; i++) begin
      rv = $random(seed);
      apb(1'b1, ridx[i], {24'h00_0000, rv});
      apb(1'b0, ridx[i], 32'h0000_0000);
      `CHK("multiplier", {24'h00_0000, rv}, rd)
      apb(1'b1, ridx[i], cval[i]);
    end
    wait_win();
    phase(8'h3C, 1'b1, 1);
    phase(8'h3D, 1'b1, 1);
    phase(8'h3C, 1'b1, 1);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("blue after restart", 1'b0, rd[2])
    phase(8'h3C, 1'b1, 1);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("blue declared", 1'b1, rd[2])
    apb(1'b0, lad_pkg::IDX_FLAGS, 32'h0000_0000);
    `CHK("blue flag rise", 1'b1, rd[2])
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, lad_pkg::IDX_IRQ_EN, 32'h0000_0004);
    `CHK("irq enabled", 1'b1, irq)
    apb(1'b1, lad_pkg::IDX_FLAGS, 32'h0000_0000);
    apb(1'b0, lad_pkg::IDX_FLAGS, 32'h0000_0000);
    `CHK("flag kept on zero", 1'b1, rd[2])
    apb(1'b1, lad_pkg::IDX_FLAGS, 32'h0000_0004);
    `CHK("irq after clear", 1'b0, irq)
    phase(8'h3D, 1'b1, 2);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("blue cleared", 1'b0, rd[2])
    `CHK("irq on fall", 1'b1, irq)
    blue_kind <= 1'b0;
    for (int f = 0; f < 6; f++) begin
      fmt <= lad_pkg::lad_fmt_type'(f);
      apb(1'b1, lad_pkg::IDX_FORMAT, 32'(f));
      phase(yel_ev(lad_pkg::lad_fmt_type'(f), 1'b0), 1'b1, 2);
      phase(yel_ev(lad_pkg::lad_fmt_type'(f), 1'b1), 1'b1, 1);
      apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
      `CHK("yellow one window", 1'b0, rd[1])
      phase(yel_ev(lad_pkg::lad_fmt_type'(f), 1'b1), 1'b1, 1);
      apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
      `CHK("yellow declared", 1'b1, rd[1])
      phase(yel_ev(lad_pkg::lad_fmt_type'(f), 1'b0), 1'b1, 2);
      apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
      `CHK("yellow cleared", 1'b0, rd[1])
    end
    phase(8'h02, 1'b0, 2);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("sync loss early", 2'b00, rd[1:0])
    phase(8'h02, 1'b0, 1);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("sync loss, yellow idle", 2'b01, rd[1:0])
    phase(8'h03, 1'b1, 3);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("sync loss held", 1'b1, rd[0])
    phase(8'h03, 1'b1, 1);
    apb(1'b0, lad_pkg::IDX_STATE, 32'h0000_0000);
    `CHK("sync loss cleared", 1'b0, rd[0])
    apb(1'b0, lad_pkg::IDX_FLAGS, 32'h0000_0000);
    `CHK("sync loss flag", 1'b1, rd[0])
    finish_test();
  end
endmodule // lad_top_tb
`default_nettype wire
